/* File: core/spq_consts.svh */
`ifndef SPQ_CONSTS_SVH
`define SPQ_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SPQ_OFF_CTRL 6'h00
`define SPQ_OFF_MODE 6'h04
`define SPQ_OFF_REPS 6'h08
`define SPQ_OFF_TMO 6'h0C
`define SPQ_OFF_STAGE_ID 6'h10
`define SPQ_OFF_SLOTS 6'h14
`define SPQ_OFF_STATUS 6'h18
`define SPQ_OFF_IDS 6'h1C
`define SPQ_OFF_REMAIN 6'h20
`define SPQ_OFF_IRQ_ST 6'h24
`define SPQ_OFF_IRQ_MSK 6'h28

// ----------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------
`define SPQ_CTRL_ENABLE 0
`define SPQ_CTRL_COMMIT 1
`define SPQ_CTRL_RESET 2
`define SPQ_CTRL_SYNC 3

// ----------------------------------------------------------------
// Interrupt status bit positions
// ----------------------------------------------------------------
`define SPQ_IRQ_DONE 0
`define SPQ_IRQ_ABORT 1
`define SPQ_IRQ_REFUSE 2

// ----------------------------------------------------------------
// Sizes, limits and timing
// ----------------------------------------------------------------
`define SPQ_SLOTS 16
`define SPQ_SLOT_W 5
`define SPQ_REPS_MAX 32'd4000000
`define SPQ_REPS_RST 32'd1
`define SPQ_CLK_HZ 200000000
`define SPQ_MS_CYC (`SPQ_CLK_HZ / 1000)

`endif

/* File: core/spq_pkg.sv */
package spq_pkg;

    // Pipeliner operating mode
    typedef enum logic [1:0] {
        SPQ_MODE_OFF = 2'h0,
        SPQ_MODE_BATCH = 2'h1,
        SPQ_MODE_QUEUE = 2'h2
    } spq_mode_e;

    // Reported status codes
    typedef enum logic [1:0] {
        SPQ_ST_IDLE = 2'h0,
        SPQ_ST_EXEC = 2'h1,
        SPQ_ST_WAIT = 2'h2,
        SPQ_ST_DONE = 2'h3
    } spq_status_e;

    // Internal sequencing states
    typedef enum logic [1:0] {
        SPQ_FSM_IDLE,
        SPQ_FSM_SYNC,
        SPQ_FSM_RUN,
        SPQ_FSM_DONE
    } spq_fsm_e;

    typedef logic [15:0] spq_id_t;

endpackage : spq_pkg

/* File: core/spq_pipeliner.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spq_consts.svh"

module spq_pipeliner
    import spq_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // Avalon-MM slave
    input wire logic [5:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Waveform sequencer handshake
    output logic seq_start_out,
    output logic [15:0] seq_id_out,
    output logic seq_abort_out,
    output logic seq_reset_out,
    input wire logic seq_done_in,
    // Cross-channel synchronisation
    output logic sync_ready_out,
    input wire logic sync_all_ready_in,
    // Interrupt
    output logic irq_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        spq_id_t [`SPQ_SLOTS-1:0] ids;
        logic [`SPQ_SLOT_W-2:0] rd_ptr;
        logic [`SPQ_SLOT_W-2:0] wr_ptr;
        logic [`SPQ_SLOT_W-1:0] used;
        logic [`SPQ_SLOT_W-2:0] run_idx;
        logic [`SPQ_SLOT_W-1:0] run_cnt;
        spq_fsm_e fsm;
        logic [1:0] mode;
        logic enable;
        logic sync_en;
        logic [31:0] reps;
        logic [31:0] remain;
        logic [31:0] tmo_ms;
        logic [31:0] ms_cnt;
        logic [17:0] cyc_cnt;
        spq_id_t stage_id;
        spq_id_t run_id;
        logic [2:0] irq_st;
        logic [2:0] irq_msk;
        logic ack;
        logic [31:0] rdata;
        logic start;
        logic abort;
        logic seq_rst;
        logic irq;
        logic wreq;
        logic sync_rdy;
    } spq_state_s;

    spq_state_s s_q;
    spq_state_s s_d;

    logic [31:0] wmask;
    logic req;
    logic [`SPQ_SLOT_W-1:0] free_slots;
    logic can_commit;
    logic [31:0] wr_val;
    logic seq_end;
    logic tmo_hit;
    logic [2:0] ev;
    logic [1:0] st_code;

    // Byte-enable mask, eight mask bits per enable bit
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{avs_byteenable_in[b]}};
        end
    end

    // Status decode
    // Status code decode
    always_comb begin
        case (s_q.fsm)
            SPQ_FSM_IDLE: st_code = (s_q.enable &&
                s_q.mode == SPQ_MODE_QUEUE) ? SPQ_ST_WAIT : SPQ_ST_IDLE;
            SPQ_FSM_SYNC: st_code = SPQ_ST_EXEC;
            SPQ_FSM_RUN: st_code = SPQ_ST_EXEC;
            SPQ_FSM_DONE: st_code = SPQ_ST_DONE;
            default: st_code = SPQ_ST_IDLE;
        endcase
    end

    assign req = (avs_read_in || avs_write_in) && !s_q.ack;
    assign free_slots = 5'(`SPQ_SLOTS) - s_q.used;
    assign can_commit = (free_slots != 5'h0_0) && s_q.mode != SPQ_MODE_OFF
        && !(s_q.mode == SPQ_MODE_BATCH && s_q.enable);
    assign tmo_hit = (s_q.fsm == SPQ_FSM_RUN) && (s_q.tmo_ms != 32'h0000_0000)
        && (s_q.ms_cnt >= s_q.tmo_ms);
    assign seq_end = (s_q.fsm == SPQ_FSM_RUN) && (seq_done_in || tmo_hit);

    // Next-state logic
    always_comb begin
        s_d = s_q;
        ev = 3'h0;
        wr_val = '0;
        s_d.start = 1'b0;
        s_d.abort = 1'b0;
        s_d.seq_rst = 1'b0;
        s_d.ack = 1'b0;
        s_d.rdata = s_q.rdata;

        // Execution engine
        case (s_q.fsm)
            SPQ_FSM_IDLE: begin
                if (s_q.enable && s_q.mode != SPQ_MODE_OFF &&
                    s_q.used != 5'h0_0) begin
                    s_d.fsm = SPQ_FSM_SYNC;
                    s_d.run_idx = s_q.rd_ptr;
                    s_d.run_cnt = 5'h0_0;
                end
            end
            SPQ_FSM_SYNC: begin
                if (!s_q.enable) begin
                    s_d.fsm = SPQ_FSM_IDLE;
                end else if (!s_q.sync_en || sync_all_ready_in) begin
                    s_d.fsm = SPQ_FSM_RUN;
                    s_d.start = 1'b1;
                    s_d.run_id = s_q.ids[s_q.run_idx];
                    s_d.ms_cnt = '0;
                    s_d.cyc_cnt = '0;
                end
            end
            SPQ_FSM_RUN: begin
                if (s_q.cyc_cnt == 18'(`SPQ_MS_CYC - 1)) begin
                    s_d.cyc_cnt = '0;
                    s_d.ms_cnt = s_q.ms_cnt + 32'h0000_0001;
                end else begin
                    s_d.cyc_cnt = s_q.cyc_cnt + 18'h0_0001;
                end
                if (seq_end) begin
                    s_d.abort = tmo_hit && !seq_done_in;
                    ev[`SPQ_IRQ_DONE] = 1'b1;
                    ev[`SPQ_IRQ_ABORT] = tmo_hit && !seq_done_in;
                    if (s_q.mode == SPQ_MODE_QUEUE) begin
                        s_d.rd_ptr = s_q.rd_ptr + 4'h1;
                        s_d.used = s_q.used - 5'h0_1;
                        s_d.fsm = SPQ_FSM_IDLE;
                    end else if (s_q.run_cnt + 5'h0_1 < s_q.used) begin
                        s_d.run_idx = s_q.run_idx + 4'h1;
                        s_d.run_cnt = s_q.run_cnt + 5'h0_1;
                        s_d.fsm = SPQ_FSM_SYNC;
                    end else if (s_q.remain > 32'h0000_0001) begin
                        s_d.remain = s_q.remain - 32'h0000_0001;
                        s_d.run_idx = s_q.rd_ptr;
                        s_d.run_cnt = 5'h0_0;
                        s_d.fsm = SPQ_FSM_SYNC;
                    end else begin
                        s_d.remain = 32'h0000_0000;
                        s_d.fsm = SPQ_FSM_DONE;
                    end
                end else if (!s_q.enable) begin
                    s_d.abort = 1'b1;
                    s_d.fsm = SPQ_FSM_IDLE;
                end
            end
            SPQ_FSM_DONE: begin
                if (!s_q.enable) begin
                    s_d.fsm = SPQ_FSM_IDLE;
                    s_d.remain = s_q.reps;
                end
            end
            default: s_d.fsm = SPQ_FSM_IDLE;
        endcase

        // Register access, one wait cycle
        if (req) begin
            s_d.ack = 1'b1;
            if (avs_write_in) begin
                case (avs_address_in)
                    `SPQ_OFF_CTRL: begin
                        wr_val = avs_writedata_in & wmask;
                        s_d.enable = wr_val[`SPQ_CTRL_ENABLE];
                        s_d.sync_en = wr_val[`SPQ_CTRL_SYNC];
                        if (wr_val[`SPQ_CTRL_COMMIT]) begin
                            if (can_commit) begin
                                s_d.ids[s_q.wr_ptr] = s_q.stage_id;
                                s_d.wr_ptr = s_q.wr_ptr + 4'h1;
                                s_d.used = s_d.used + 5'h0_1;
                            end else begin
                                ev[`SPQ_IRQ_REFUSE] = 1'b1;
                            end
                        end
                        if (wr_val[`SPQ_CTRL_RESET]) begin
                            s_d.used = 5'h0_0;
                            s_d.rd_ptr = 4'h0;
                            s_d.wr_ptr = 4'h0;
                            s_d.enable = 1'b0;
                            s_d.abort = s_q.fsm == SPQ_FSM_RUN;
                            s_d.fsm = SPQ_FSM_IDLE;
                            s_d.remain = s_q.reps;
                        end
                    end
                    `SPQ_OFF_MODE: begin
                        wr_val = (32'(s_q.mode) & ~wmask) |
                            (avs_writedata_in & wmask);
                        if (wr_val[1:0] != s_q.mode &&
                            wr_val[1:0] != 2'h3) begin
                            s_d.mode = wr_val[1:0];
                            s_d.used = 5'h0_0;
                            s_d.rd_ptr = 4'h0;
                            s_d.wr_ptr = 4'h0;
                            s_d.enable = 1'b0;
                            s_d.fsm = SPQ_FSM_IDLE;
                            s_d.seq_rst = 1'b1;
                            s_d.reps = `SPQ_REPS_RST;
                            s_d.remain = `SPQ_REPS_RST;
                        end
                    end
                    `SPQ_OFF_REPS: begin
                        wr_val = (s_q.reps & ~wmask) |
                            (avs_writedata_in & wmask);
                        // Accept 1 to 4e6 in batch
                        if (s_q.mode == SPQ_MODE_BATCH &&
                            wr_val != 32'h0000_0000 &&
                            wr_val <= `SPQ_REPS_MAX) begin
                            s_d.reps = wr_val;
                            if (s_q.fsm == SPQ_FSM_IDLE) begin
                                s_d.remain = wr_val;
                            end
                        end
                    end
                    `SPQ_OFF_TMO: begin
                        s_d.tmo_ms = (s_q.tmo_ms & ~wmask) |
                            (avs_writedata_in & wmask);
                    end
                    `SPQ_OFF_STAGE_ID: begin
                        wr_val = (32'(s_q.stage_id) & ~wmask) |
                            (avs_writedata_in & wmask);
                        s_d.stage_id = wr_val[15:0];
                    end
                    `SPQ_OFF_IRQ_ST: begin
                        s_d.irq_st = s_q.irq_st & ~avs_writedata_in[2:0];
                    end
                    `SPQ_OFF_IRQ_MSK: begin
                        s_d.irq_msk = avs_writedata_in[2:0];
                    end
                    default: ;
                endcase
            end else begin
                case (avs_address_in)
                    `SPQ_OFF_CTRL: s_d.rdata = {28'h000_0000, s_q.sync_en,
                        2'h0, s_q.enable};
                    `SPQ_OFF_MODE: s_d.rdata = {30'h0000_0000, s_q.mode};
                    `SPQ_OFF_REPS: s_d.rdata = s_q.reps;
                    `SPQ_OFF_TMO: s_d.rdata = s_q.tmo_ms;
                    `SPQ_OFF_STAGE_ID: s_d.rdata = {16'h0000, s_q.stage_id};
                    `SPQ_OFF_SLOTS: s_d.rdata = {11'h000, 5'(`SPQ_SLOTS),
                        11'h000, free_slots};
                    `SPQ_OFF_STATUS: s_d.rdata = {29'h0000_0000,
                        can_commit, st_code};
                    `SPQ_OFF_IDS: s_d.rdata = {s_q.run_id, s_q.stage_id};
                    `SPQ_OFF_REMAIN: s_d.rdata =
                        (s_q.mode == SPQ_MODE_BATCH) ? s_q.remain
                        : 32'h0000_0001;
                    `SPQ_OFF_IRQ_ST: s_d.rdata = {29'h0000_0000, s_q.irq_st};
                    `SPQ_OFF_IRQ_MSK: s_d.rdata = {29'h0000_0000, s_q.irq_msk};
                    default: s_d.rdata = 32'h0000_0000;
                endcase
            end
        end

        // Events set after clears so set wins
        s_d.irq_st = s_d.irq_st | ev;
        s_d.irq = |(s_d.irq_st & s_d.irq_msk);
        // Handshake outputs registered, no gate after the flop
        s_d.wreq = !s_d.ack;
        s_d.sync_rdy = s_d.fsm == SPQ_FSM_SYNC;
    end

    // State register
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_q <= '0;
            s_q.fsm <= SPQ_FSM_IDLE;
            s_q.mode <= SPQ_MODE_OFF;
            s_q.reps <= `SPQ_REPS_RST;
            s_q.remain <= `SPQ_REPS_RST;
            s_q.wreq <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign avs_readdata_out = s_q.rdata;
    assign avs_waitrequest_out = s_q.wreq;
    assign seq_start_out = s_q.start;
    assign seq_id_out = s_q.run_id;
    assign seq_abort_out = s_q.abort;
    assign seq_reset_out = s_q.seq_rst;
    assign sync_ready_out = s_q.sync_rdy;
    assign irq_out = s_q.irq;

endmodule : spq_pipeliner

`default_nettype wire

/* File: sim/spq_pipeliner_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spq_consts.svh"

module spq_pipeliner_asserts
    import spq_pkg::*;
(
    // Clock, reset and bus
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic [5:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    // Sequencer, sync and interrupt
    input wire logic seq_start_out,
    input wire logic [15:0] seq_id_out,
    input wire logic seq_abort_out,
    input wire logic seq_reset_out,
    input wire logic seq_done_in,
    input wire logic sync_ready_out,
    input wire logic sync_all_ready_in,
    input wire logic irq_out
);
    // ----------------------------------------
    // Shadow state
    // ----------------------------------------
    logic acc;
    logic ctl_w;
    logic en_q;
    logic sync_q;
    logic [1:0] mode_q;

    // Accepted writes
    assign acc = avs_write_in && !avs_waitrequest_out;
    assign ctl_w = acc && avs_address_in == `SPQ_OFF_CTRL;

    // Track mode, enable and sync settings
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_q <= 2'h0;
            en_q <= 1'b0;
            sync_q <= 1'b0;
        end else if (ctl_w) begin
            en_q <= avs_writedata_in[0] && !avs_writedata_in[2];
            sync_q <= avs_writedata_in[3];
        end else if (acc && avs_address_in == `SPQ_OFF_MODE
                     && avs_writedata_in[1:0] != 2'h3) begin
            mode_q <= avs_writedata_in[1:0];
        end
    end

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_bus_answer: assert property ($rose(avs_write_in || avs_read_in)
        |=> !avs_waitrequest_out) else $error("no bus answer");
    a_wait_single: assert property (!avs_waitrequest_out
        |=> avs_waitrequest_out) else $error("wait low too long");
    a_start_pulse: assert property (seq_start_out
        |=> !seq_start_out) else $error("start not a pulse");
    a_start_id: assert property (seq_start_out
        |=> $stable(seq_id_out)) else $error("running id moved");
    a_start_enabled: assert property (seq_start_out
        |-> $past(en_q) || $past(en_q, 2)) else $error("start while off");
    a_sync_gate: assert property (sync_q && sync_ready_out
        && !sync_all_ready_in |=> !seq_start_out) else $error("sync gate");
    a_abort_pulse: assert property (seq_abort_out
        |=> !seq_abort_out) else $error("abort not a pulse");
    a_mode_reset: assert property (acc
        && avs_address_in == `SPQ_OFF_MODE
        && avs_writedata_in[1:0] != 2'h3 && avs_writedata_in[1:0] != mode_q
        |-> seq_reset_out) else $error("mode change no reset");
    a_reset_clear: assert property (ctl_w && avs_writedata_in[2]
        |-> ##2 (!sync_ready_out)[*2]) else $error("reset left gate");
endmodule : spq_pipeliner_asserts

bind spq_pipeliner spq_pipeliner_asserts u_chk (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .seq_start_out(seq_start_out), .seq_id_out(seq_id_out),
    .seq_abort_out(seq_abort_out), .seq_reset_out(seq_reset_out),
    .seq_done_in(seq_done_in), .sync_ready_out(sync_ready_out),
    .sync_all_ready_in(sync_all_ready_in), .irq_out(irq_out)
);

`default_nettype wire

/* File: sim/spq_pipeliner_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spq_consts.svh"

module spq_pipeliner_tb_top;
    import spq_pkg::*;
    logic clk, rst_b, rd_en, wr_en, done, sall;
    logic wreq, start, abrt, sreset, sready, irq, srs;
    logic [5:0] adr;
    logic [31:0] wd, rdat, q;
    logic [15:0] sid;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;

    // Device under test
    spq_pipeliner DUT (
        .clk_sys_in(clk), .rst_b_in(rst_b), .avs_address_in(adr),
        .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wreq), .seq_start_out(start),
        .seq_id_out(sid), .seq_abort_out(abrt), .seq_reset_out(sreset),
        .seq_done_in(done), .sync_ready_out(sready),
        .sync_all_ready_in(sall), .irq_out(irq)
    );

    // Clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            print_verdict();
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic print_verdict;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s exp %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic ack;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        q = rdat;
        srs = sreset;
    endtask : ack

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr_en <= 1'b1;
        ack();
        wr_en <= 1'b0;
    endtask : wr

    task automatic rchk(input logic [5:0] a, input logic [31:0] e, m);
        @(posedge clk);
        adr <= a;
        rd_en <= 1'b1;
        ack();
        rd_en <= 1'b0;
        chk($sformatf("reg %h", a), q & m, e);
    endtask : rchk

    task automatic run_one(input logic [15:0] id);
        int i;
        @(negedge clk);
        for (i = 0; i < 200 && start !== 1'b1; i++) @(negedge clk);
        chk("seq_start", {31'h0, start}, 32'h1);
        chk("seq_id", {16'h0, sid}, {16'h0, id});
    endtask : run_one

    task automatic fin;
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
    endtask : fin

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rchk(`SPQ_OFF_SLOTS, 32'h0010_0010, 32'hFFFF_FFFF);
        rchk(`SPQ_OFF_REMAIN, 32'h0000_0001, 32'hFFFF_FFFF);
        rchk(`SPQ_OFF_STATUS, 32'h0000_0000, 32'h0000_0007);
        rchk(`SPQ_OFF_MODE, 32'h0000_0000, 32'h0000_0003);
    endtask : t_reset

    task automatic t_off;
        wr(`SPQ_OFF_IRQ_MSK, 32'h0000_0004);
        wr(`SPQ_OFF_CTRL, 32'h0000_0002);
        wr(`SPQ_OFF_REPS, 32'h0000_0005);
        rchk(`SPQ_OFF_REPS, 32'h0000_0001, 32'hFFFF_FFFF);
        rchk(`SPQ_OFF_IRQ_ST, 32'h0000_0004, 32'h0000_0007);
        chk("irq_out", {31'h0, irq}, 32'h1);
        wr(`SPQ_OFF_IRQ_ST, 32'h0000_0004);
        rchk(`SPQ_OFF_IRQ_ST, 32'h0000_0000, 32'h0000_0007);
        chk("irq_out", {31'h0, irq}, 32'h0);
    endtask : t_off

    task automatic t_batch;
        int i, r;
        wr(`SPQ_OFF_MODE, 32'h0000_0001);
        chk("seq_reset", {31'h0, srs}, 32'h1);
        wr(`SPQ_OFF_REPS, 32'h0000_0000);
        wr(`SPQ_OFF_REPS, 32'h003D_0901);
        rchk(`SPQ_OFF_REPS, 32'h0000_0001, 32'hFFFF_FFFF);
        wr(`SPQ_OFF_REPS, 32'h0000_0002);
        rchk(`SPQ_OFF_REPS, 32'h0000_0002, 32'hFFFF_FFFF);
        for (i = 0; i < 2; i++) begin
            wr(`SPQ_OFF_STAGE_ID, 32'h0000_00A0 + i);
            wr(`SPQ_OFF_CTRL, 32'h0000_0002);
        end
        rchk(`SPQ_OFF_IDS, 32'h0000_00A1, 32'h0000_FFFF);
        rchk(`SPQ_OFF_SLOTS, 32'h0010_000E, 32'hFFFF_FFFF);
        wr(`SPQ_OFF_CTRL, 32'h0000_0001);
        for (r = 0; r < 2; r++) begin
            for (i = 0; i < 2; i++) begin
                run_one(16'h00A0 + i[15:0]);
                fin();
            end
        end
        rchk(`SPQ_OFF_STATUS, 32'h0000_0003, 32'h0000_0007);
        wr(`SPQ_OFF_CTRL, 32'h0000_0005);
        rchk(`SPQ_OFF_SLOTS, 32'h0010_0010, 32'hFFFF_FFFF);
        rchk(`SPQ_OFF_STATUS, 32'h0000_0004, 32'h0000_0007);
    endtask : t_batch

    task automatic t_queue;
        int i;
        wr(`SPQ_OFF_MODE, 32'h0000_0002);
        rchk(`SPQ_OFF_REMAIN, 32'h0000_0001, 32'hFFFF_FFFF);
        rchk(`SPQ_OFF_REPS, 32'h0000_0001, 32'hFFFF_FFFF);
        sall <= 1'b0;
        wr(`SPQ_OFF_CTRL, 32'h0000_0009);
        rchk(`SPQ_OFF_STATUS, 32'h0000_0006, 32'h0000_0007);
        wr(`SPQ_OFF_STAGE_ID, 32'h0000_00B1);
        wr(`SPQ_OFF_CTRL, 32'h0000_000B);
        q = 32'h0;
        for (i = 0; i < 20; i++) begin
            @(negedge clk);
            q[0] = q[0] | start;
        end
        chk("early start", q, 32'h0);
        chk("sync_ready", {31'h0, sready}, 32'h1);
        @(posedge clk);
        sall <= 1'b1;
        run_one(16'h00B1);
        rchk(`SPQ_OFF_STATUS, 32'h0000_0005, 32'h0000_0007);
        rchk(`SPQ_OFF_SLOTS, 32'h0010_000F, 32'hFFFF_FFFF);
        fin();
        rchk(`SPQ_OFF_SLOTS, 32'h0010_0010, 32'hFFFF_FFFF);
        rchk(`SPQ_OFF_STATUS, 32'h0000_0006, 32'h0000_0007);
        wr(`SPQ_OFF_STAGE_ID, 32'h0000_00B2);
        wr(`SPQ_OFF_CTRL, 32'h0000_0003);
        run_one(16'h00B2);
        wr(`SPQ_OFF_CTRL, 32'h0000_0000);
        for (i = 0; i < 50 && abrt !== 1'b1; i++) @(negedge clk);
        chk("seq_abort", {31'h0, abrt}, 32'h1);
    endtask : t_queue

    task automatic t_full;
        int i;
        wr(`SPQ_OFF_CTRL, 32'h0000_0004);
        wr(`SPQ_OFF_IRQ_ST, 32'h0000_0007);
        for (i = 0; i < 16; i++) wr(`SPQ_OFF_CTRL, 32'h0000_0002);
        rchk(`SPQ_OFF_SLOTS, 32'h0010_0000, 32'hFFFF_FFFF);
        rchk(`SPQ_OFF_IRQ_ST, 32'h0000_0000, 32'h0000_0004);
        rchk(`SPQ_OFF_STATUS, 32'h0000_0000, 32'h0000_0007);
        wr(`SPQ_OFF_CTRL, 32'h0000_0002);
        rchk(`SPQ_OFF_IRQ_ST, 32'h0000_0004, 32'h0000_0004);
        rchk(`SPQ_OFF_SLOTS, 32'h0010_0000, 32'hFFFF_FFFF);
        rchk(6'h3C, 32'h0000_0000, 32'hFFFF_FFFF);
        wr(`SPQ_OFF_TMO, 32'h0000_0001);
        rchk(`SPQ_OFF_TMO, 32'h0000_0001, 32'hFFFF_FFFF);
        wr(`SPQ_OFF_TMO, 32'h0000_0000);
        wr(`SPQ_OFF_MODE, 32'h0000_0000);
        chk("seq_reset", {31'h0, srs}, 32'h1);
        rchk(`SPQ_OFF_SLOTS, 32'h0010_0010, 32'hFFFF_FFFF);
    endtask : t_full

    // Main sequence
    initial begin
        rst_b = 1'b0;
        rd_en = 1'b0;
        wr_en = 1'b0;
        done = 1'b0;
        sall = 1'b1;
        adr = 6'h00;
        wd = 32'h0000_0000;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_off();
        t_batch();
        t_queue();
        t_full();
        print_verdict();
    end
endmodule : spq_pipeliner_tb_top

`default_nettype wire
